// ---- common/odt_pkg.sv ----
`default_nettype none
package odt_pkg;
  localparam int ODT_VAL_W = 16;
  localparam int ODT_DREG_AW = 8;
  localparam int ODT_TIMER_MAX = 200;
  localparam int ODT_TIMER_MAX_SMALL = 100;
  localparam int ODT_CLK_PERIOD_NS = 40;
  localparam int ODT_BASE_TICK_NS = 1000000;
  localparam int ODT_CYC_PER_MS = ODT_BASE_TICK_NS / ODT_CLK_PERIOD_NS;
  localparam logic [ODT_VAL_W-1:0] ODT_CUR_RST = 16'h0000;
  localparam logic [ODT_VAL_W-1:0] ODT_PRESET_INIT = 16'h0000;

  typedef enum logic [1:0] {
    ODT_UNIT_1S = 2'h0,
    ODT_UNIT_100MS = 2'h1,
    ODT_UNIT_10MS = 2'h2,
    ODT_UNIT_1MS = 2'h3
  } odt_unit_t;

  localparam logic [15:0] ODT_LEN_1S = 16'd1000;
  localparam logic [15:0] ODT_LEN_100MS = 16'd100;
  localparam logic [15:0] ODT_LEN_10MS = 16'd10;
  localparam logic [15:0] ODT_LEN_1MS = 16'd1;

  typedef enum logic [2:0] {
    ODT_ST_IDLE = 3'b001,
    ODT_ST_COUNT = 3'b010,
    ODT_ST_DONE = 3'b100
  } odt_state_t;

  typedef struct packed {
    logic preset_from_dreg;
    logic [ODT_DREG_AW-1:0] dreg_num;
    odt_unit_t tick_unit_select;
  } odt_cfg_t;

  typedef struct packed {
    logic en;
    logic [ODT_DREG_AW-1:0] addr;
    logic [ODT_VAL_W-1:0] data;
  } odt_wr_t;
endpackage
`default_nettype wire

// ---- core/odt_dreg_mem.sv ----
`default_nettype none
module odt_dreg_mem
  import odt_pkg::*;
#(
  parameter int AW = ODT_DREG_AW,
  parameter int DW = ODT_VAL_W
) (
  input wire logic core_clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);
  logic [DW-1:0] mem_r [0:(1<<AW)-1];

  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end

  // registered read, one cycle latency
  always_ff @(posedge core_clk_i) begin
    rd_data_o <= mem_r[rd_addr_i];
  end
endmodule
`default_nettype wire

// ---- core/odt_on_delay_up_timer.sv ----
// Functional notes
// - while run_input is low the current value is zero and the timer output is off.
// - when run_input rises the current value counts up and keeps counting while high, stopping at the preset.
// - after counting stops the current value holds and the output stays on until run_input falls or the preset is raised above the current value.
// - the output is on exactly when run_input is high and the current value is at or above the preset, off otherwise.
// - preset and current value are unsigned 16-bit quantities, 0 to 65535.
// - the preset comes either from the stored constant or indirectly from a numbered data register.
// - each timer selects a time unit of 1 s, 100 ms, 10 ms or 1 ms per count.
// - a preset raised above the current value during counting lets counting continue up to it.
// - a preset dropped to or below the current value during counting stops it and turns the output on at once.
// - timer indices run 0 to 199, or 0 to 99 on the small variant, each index used once.
// - run-time preset changes live in volatile storage and power-up restores the nonvolatile preset.
// - a commit request copies the changed preset into nonvolatile storage, losing the original.
// - counting follows a free-running 16-bit reference timer, so the first count may come up to one unit early.
`default_nettype none
module odt_on_delay_up_timer
  import odt_pkg::*;
#(
  parameter int TIMER_INDEX = 0,
  parameter bit SMALL_VARIANT = 1'b0,
  parameter int CYC_PER_MS = ODT_CYC_PER_MS,
  parameter logic [ODT_VAL_W-1:0] PRESET_NV_INIT = ODT_PRESET_INIT
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic run_input_i,
  input wire odt_cfg_t cfg_i,
  input wire logic preset_wr_i,
  input wire logic [ODT_VAL_W-1:0] preset_wr_data_i,
  input wire logic preset_commit_i,
  input wire odt_wr_t dreg_wr_i,
  output logic timer_out_o,
  output logic [ODT_VAL_W-1:0] cur_value_o,
  output logic [ODT_VAL_W-1:0] preset_value_o,
  output logic [ODT_VAL_W-1:0] preset_nv_o,
  output logic counting_o,
  output logic index_bad_o
);
  localparam int IDX_LIMIT = SMALL_VARIANT ? ODT_TIMER_MAX_SMALL : ODT_TIMER_MAX;
  localparam bit IDX_BAD = (TIMER_INDEX < 0) || (TIMER_INDEX >= IDX_LIMIT);

  odt_state_t state_r, state_nxt;
  logic [ODT_VAL_W-1:0] cur_r, cur_nxt;
  logic [ODT_VAL_W-1:0] preset_vol_r;
  logic [ODT_VAL_W-1:0] preset_nv_r;
  logic [ODT_VAL_W-1:0] dreg_rd;
  logic [ODT_VAL_W-1:0] preset_eff;
  logic [31:0] pre_cnt_r;
  logic ms_tick_r;
  logic [15:0] ref_r;
  logic [15:0] unit_len;
  logic unit_tick;

  // index is fixed at build time; a bad one is flagged rather than refused
  always_ff @(posedge core_clk_i) begin
    index_bad_o <= IDX_BAD;
  end

  // nonvolatile copy survives reset; only a commit changes it
  // power-up marker: without a start value the nv copy would never load
  logic nv_loaded_r = 1'b0;
  always_ff @(posedge core_clk_i) begin
    if (!nv_loaded_r) begin
      preset_nv_r <= PRESET_NV_INIT;
    end else if (preset_commit_i) begin
      preset_nv_r <= preset_vol_r;
    end
  end

  always_ff @(posedge core_clk_i) begin
    nv_loaded_r <= 1'b1;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !nv_loaded_r) begin
      preset_vol_r <= nv_loaded_r ? preset_nv_r : PRESET_NV_INIT;
    end else if (preset_wr_i) begin
      preset_vol_r <= preset_wr_data_i;
    end
  end

  odt_dreg_mem #(
    .AW(ODT_DREG_AW),
    .DW(ODT_VAL_W)
  ) u_dreg (
    .core_clk_i(core_clk_i),
    .wr_en_i(dreg_wr_i.en),
    .wr_addr_i(dreg_wr_i.addr),
    .wr_data_i(dreg_wr_i.data),
    .rd_addr_i(cfg_i.dreg_num),
    .rd_data_o(dreg_rd)
  );

  assign preset_eff = cfg_i.preset_from_dreg ? dreg_rd : preset_vol_r;

  // 1 ms base tick from the core clock
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pre_cnt_r <= 32'h0000_0000;
      ms_tick_r <= 1'b0;
    end else if (pre_cnt_r == 32'(CYC_PER_MS - 1)) begin
      pre_cnt_r <= 32'h0000_0000;
      ms_tick_r <= 1'b1;
    end else begin
      pre_cnt_r <= pre_cnt_r + 32'h0000_0001;
      ms_tick_r <= 1'b0;
    end
  end

  always_comb begin
    case (cfg_i.tick_unit_select)
      ODT_UNIT_1S: unit_len = ODT_LEN_1S;
      ODT_UNIT_100MS: unit_len = ODT_LEN_100MS;
      ODT_UNIT_10MS: unit_len = ODT_LEN_10MS;
      ODT_UNIT_1MS: unit_len = ODT_LEN_1MS;
      default: unit_len = ODT_LEN_1MS;
    endcase
  end

  // reference runs regardless of run_input, hence the early first count
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ref_r <= 16'h0000;
    end else if (ms_tick_r) begin
      ref_r <= (ref_r >= unit_len - 16'h0001) ? 16'h0000 : ref_r + 16'h0001;
    end
  end

  assign unit_tick = ms_tick_r && (ref_r >= unit_len - 16'h0001);

  always_comb begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    case (state_r)
      ODT_ST_IDLE: begin
        cur_nxt = ODT_CUR_RST;
        if (run_input_i) begin
          state_nxt = (cur_r >= preset_eff) ? ODT_ST_DONE : ODT_ST_COUNT;
        end
      end
      ODT_ST_COUNT: begin
        if (!run_input_i) begin
          state_nxt = ODT_ST_IDLE;
          cur_nxt = ODT_CUR_RST;
        end else if (cur_r >= preset_eff) begin
          state_nxt = ODT_ST_DONE;
        end else if (unit_tick) begin
          cur_nxt = cur_r + 16'h0001;
          if (cur_r + 16'h0001 >= preset_eff) begin
            state_nxt = ODT_ST_DONE;
          end
        end
      end
      ODT_ST_DONE: begin
        if (!run_input_i) begin
          state_nxt = ODT_ST_IDLE;
          cur_nxt = ODT_CUR_RST;
        end else if (cur_r < preset_eff) begin
          state_nxt = ODT_ST_COUNT;
        end
      end
      default: begin
        state_nxt = ODT_ST_IDLE;
        cur_nxt = ODT_CUR_RST;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_r <= ODT_ST_IDLE;
      cur_r <= ODT_CUR_RST;
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
    end
  end

  // outputs track next state so they land with the count
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      timer_out_o <= 1'b0;
      cur_value_o <= ODT_CUR_RST;
      counting_o <= 1'b0;
      preset_value_o <= ODT_PRESET_INIT;
      preset_nv_o <= ODT_PRESET_INIT;
    end else begin
      timer_out_o <= run_input_i && (cur_nxt >= preset_eff);
      cur_value_o <= cur_nxt;
      counting_o <= (state_nxt == ODT_ST_COUNT);
      preset_value_o <= preset_eff;
      preset_nv_o <= preset_nv_r;
    end
  end
endmodule
`default_nettype wire

// ---- test/odt_timer_properties.sv ----
`default_nettype none
module odt_timer_properties
  import odt_pkg::*;
#(parameter int CYC_PER_MS = 4) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic run_input_i,
  input wire odt_cfg_t cfg_i,
  input wire logic preset_commit_i,
  input wire logic timer_out_o,
  input wire logic [ODT_VAL_W-1:0] cur_value_o,
  input wire logic [ODT_VAL_W-1:0] preset_value_o,
  input wire logic [ODT_VAL_W-1:0] preset_nv_o,
  input wire logic counting_o
);
  // one spare cycle: the free-running reference may tick just before counting starts
  localparam int TMAX = CYC_PER_MS + 1;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_idle_clear: assert property (
    !run_input_i |=> cur_value_o == 16'h0000 && !timer_out_o) else $error("not cleared");
  chk_tick_bound: assert property (
    counting_o && cfg_i.tick_unit_select == ODT_UNIT_1MS |-> ##[1:TMAX] (cur_value_o != $past(cur_value_o) || !counting_o))
    else $error("no tick");
  chk_step_one: assert property (
    $past(run_input_i) && cur_value_o != $past(cur_value_o) |-> cur_value_o == $past(cur_value_o) + 16'h0001)
    else $error("bad step");
  chk_out_ge: assert property (
    $past(run_input_i) && $stable(preset_value_o) |-> timer_out_o == (cur_value_o >= preset_value_o))
    else $error("out wrong");
  chk_done_hold: assert property (
    $past(run_input_i) && $past(timer_out_o) && $stable(preset_value_o) && $past(preset_value_o, 2) == preset_value_o
    |-> $stable(cur_value_o) && timer_out_o) else $error("not held");
  chk_busy_off: assert property (
    counting_o |-> !timer_out_o) else $error("out while counting");
  chk_commit_copy: assert property (
    preset_commit_i && !cfg_i.preset_from_dreg |-> ##2 preset_nv_o == $past(preset_value_o)) else $error("no commit");
  chk_nv_keep: assert property (
    !$past(preset_commit_i, 2) && !$past(sys_rst_i) && !$past(sys_rst_i, 2) |-> $stable(preset_nv_o))
    else $error("nv changed");
  cover property (counting_o ##1 timer_out_o);
  cover property (preset_commit_i);
  cover property (run_input_i && timer_out_o && cur_value_o == 16'h0000);
endmodule
bind odt_on_delay_up_timer odt_timer_properties #(.CYC_PER_MS(CYC_PER_MS)) chk_u (
  .core_clk_i(core_clk_i),
  .sys_rst_i(sys_rst_i),
  .run_input_i(run_input_i),
  .cfg_i(cfg_i),
  .preset_commit_i(preset_commit_i),
  .timer_out_o(timer_out_o),
  .cur_value_o(cur_value_o),
  .preset_value_o(preset_value_o),
  .preset_nv_o(preset_nv_o),
  .counting_o(counting_o)
);
`default_nettype wire

// ---- test/odt_user_model.sv ----
`default_nettype none
module odt_user_model (
  input wire logic clk_i,
  input wire logic go_i,
  output logic run_o = 1'b0
);
  // user logic updates its coil once a scan, so run lags the request by a cycle
  always @(posedge clk_i) begin
    run_o <= go_i;
  end
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import odt_pkg::*;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, run, pwr = 1'b0, pcom = 1'b0, out, cnt, bad;
  logic [15:0] pdat = 16'h0000, cur, pv, nv, c;
  odt_cfg_t cfg = '{1'b0, 8'h07, ODT_UNIT_1MS};
  odt_wr_t dwr = '0;
  int n_mismatch = 0, total_checks = 0, cyc = 0, n;
  int len[4] = '{1000, 100, 10, 1};
  always #20 clk = ~clk;
  odt_user_model user_u (.clk_i(clk), .go_i(go), .run_o(run));
  odt_on_delay_up_timer #(.CYC_PER_MS(4), .PRESET_NV_INIT(16'h0003)) dut_u (.core_clk_i(clk), .sys_rst_i(rst),
    .run_input_i(run), .cfg_i(cfg), .preset_wr_i(pwr), .preset_wr_data_i(pdat), .preset_commit_i(pcom),
    .dreg_wr_i(dwr), .timer_out_o(out), .cur_value_o(cur), .preset_value_o(pv), .preset_nv_o(nv),
    .counting_o(cnt), .index_bad_o(bad));
  task automatic cmp(string s, logic [16:0] e, logic [16:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  task automatic tk(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [15:0] d);
    @(posedge clk) {pwr, pdat} <= {1'b1, d};
    @(posedge clk) pwr <= 1'b0;
    #1;
  endtask
  task automatic runs(bit g);
    @(posedge clk) go <= g;
    #1;
  endtask
  task automatic upto(logic [15:0] v);
    n = 0;
    while (cur !== v && n < 20000) begin
      tk(1);
      n++;
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    tk(2);
    cmp("preset", {1'b0, 16'h0003}, {1'b0, pv});
    cmp("index", 17'h00000, {16'h0000, bad});
    runs(1);
    tk(2);
    cmp("counting", 17'h00001, {16'h0000, cnt});
    upto(16'h0003);
    cmp("done", {1'b1, 16'h0003}, {out, cur});
    cmp("stopped", 17'h00000, {16'h0000, cnt});
    tk(12);
    cmp("hold", {1'b1, 16'h0003}, {out, cur});
    runs(0);
    tk(3);
    cmp("clear", 17'h00000, {out, cur});
    $display("count test done");
    wr(16'h0002);
    for (int u = 0; u < 4; u++) begin
      @(posedge clk) cfg.tick_unit_select <= odt_unit_t'(u);
      runs(1);
      upto(16'h0002);
      cmp("unit", 17'h00001, {16'h0000, n >= len[u] * 4 - 1 && n <= len[u] * 8 + 4});
      runs(0);
      tk(2);
    end
    $display("unit test done");
    runs(1);
    upto(16'h0001);
    wr(16'h0005);
    upto(16'h0005);
    cmp("raise", {1'b1, 16'h0005}, {out, cur});
    runs(0);
    wr(16'h000a);
    runs(1);
    upto(16'h0004);
    wr(16'h0002);
    tk(2);
    c = cur;
    tk(9);
    cmp("lower", {1'b1, c}, {out, cur});
    runs(0);
    wr(16'h0000);
    runs(1);
    tk(3);
    cmp("zero", {1'b1, 16'h0000}, {out, cur});
    runs(0);
    @(posedge clk) {dwr, cfg.preset_from_dreg} <= {1'b1, 8'h07, 16'h0002, 1'b1};
    @(posedge clk) {dwr.en, go} <= 2'b01;
    upto(16'h0002);
    cmp("dreg", {1'b1, 16'h0002}, {out, pv});
    @(posedge clk) {cfg.preset_from_dreg, go} <= 2'b00;
    $display("preset change test done");
    wr(16'h0009);
    @(posedge clk) pcom <= 1'b1;
    @(posedge clk) pcom <= 1'b0;
    wr(16'h0004);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    tk(3);
    cmp("restore", {1'b0, 16'h0009}, {1'b0, pv});
    cmp("nv", {1'b0, 16'h0009}, {1'b0, nv});
    $display("commit test done");
    end_of_test();
  end
endmodule
`default_nettype wire
